/* File: rtl/pme_event_unit.sv */
// Dual counter PWM and pulse accumulator with Wishbone registers
//
// Contract
// - First counter counts selector one, clears at period
// - Period match: event, clear, output to idle level
// - Polarity zero: duty match drives output high
// - Duty percent is 100 times one minus duty/period
// - Mode 1: second counter counts selector two
// - Second event at irq compare, gated by enable
// - First pin edges: rising, falling or both
// - Scaled clock gated by pin active level
// - Second pin: rising or falling edge only
// - Selector two may take unscaled clock always
// - Output enable drives pin with chosen polarity
// - Mode 2: period matches clock second counter
// - Mode 2 increment same cycle as clear
// - Mode 2 first counter keeps its clock choices
// - Duty match flips output per polarity
// - Mode 2 leaves second input unused
// - Output disabled: duty compare is ignored
// - Clear compare takes any 8-bit value
// - Mode 3: clear matches clock first counter
// - Mode 3 second unit divides by clear value
// - Mode bits 0,1 give independent mode 1
// - Three bits pick divide by 1 to 128
// - Polarity one: period sets, duty clears output
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
module pme_event_unit (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Event input pins
    input  wire logic        first_event_input_i,
    input  wire logic        second_event_input_i,
    // PWM output pin
    output logic             pwm_out_o,
    output logic             pwm_oe_o,
    // Interrupt requests
    output logic             period_event_irq_o,
    output logic             accum_event_irq_o
);
    import pme_pkg::*;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          dat;
        pme_mode_t            mode;
        logic [2:0]           pre;
        logic                 oen;
        logic                 pol;
        logic [2:0]           sel1;
        logic [2:0]           sel2;
        logic [7:0]           period;
        logic [7:0]           duty;
        logic [7:0]           aclr;
        logic [7:0]           airq;
        logic [1:0]           pend;
        logic [1:0]           ien;
        logic                 pwm;
        logic                 irq1;
        logic                 irq2;
        logic [PME_PRE_W-1:0] pre_cnt;
        logic                 in1_q;
        logic                 in2_q;
    } pme_state_t;

    pme_state_t state_reg;
    pme_state_t state_next;

    logic                 scaled_tick;
    logic [PME_PRE_W-1:0] pre_mask;
    logic                 sel1_tick;
    logic                 sel2_tick;
    logic                 tick1;
    logic                 tick2;
    logic [7:0]           cnt1;
    logic [7:0]           cnt2;
    logic                 per_hit;
    logic                 duty_hit;
    logic                 aclr_hit;
    logic                 airq_hit;
    logic                 per_evt;
    logic                 duty_evt;
    logic                 acc_evt;
    logic                 acc_clr_evt;
    logic                 wb_go;
    logic                 wb_wr;

    // Counter selector: decode one input unit
    function automatic logic pme_select(
        input logic [2:0] code,
        input logic       first,
        input logic       scaled,
        input logic       pin,
        input logic       pin_q
    );
        logic res;
        res = 1'b0;
        unique case (code)
            PME_SEL_STOP:    res = 1'b0;
            PME_SEL_SCALED:  res = scaled;
            PME_SEL_GATE_LO: res = scaled & pin;
            PME_SEL_GATE_HI: res = scaled & ~pin;
            PME_SEL_FALL:    res = pin_q & ~pin;
            PME_SEL_RISE:    res = ~pin_q & pin;
            // second unit has no both-edge code
            PME_SEL1_BOTH:   res = first ? (pin_q ^ pin) : 1'b1;
            PME_SEL1_UNSCALE: res = first;
            default:         res = 1'b0;
        endcase
        return res;
    endfunction

    // prescale divide by power of two
    assign pre_mask    = PME_PRE_W'((8'h01 << state_reg.pre) - 8'h01);
    assign scaled_tick = ((state_reg.pre_cnt & pre_mask) == pre_mask);

    assign sel1_tick = pme_select(state_reg.sel1, 1'b1, scaled_tick,
                                  first_event_input_i, state_reg.in1_q);
    assign sel2_tick = pme_select(state_reg.sel2, 1'b0, scaled_tick,
                                  second_event_input_i, state_reg.in2_q);

    always_comb
    begin
        tick1 = sel1_tick;
        tick2 = sel2_tick;
        unique case (state_reg.mode)
            PME_MODE_0, PME_MODE_1:
            begin
                tick1 = sel1_tick;
                tick2 = sel2_tick;
            end
            PME_MODE_2:
            begin
                tick1 = sel1_tick;
                tick2 = sel1_tick & per_hit;
            end
            PME_MODE_3:
            begin
                tick1 = sel2_tick & aclr_hit;
                tick2 = sel2_tick;
            end
        endcase
    end

    pme_ctr_unit u_pwm_counter (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick1),
        .clr_cmp_i (state_reg.period),
        .evt_cmp_i (state_reg.duty),
        .count_o   (cnt1),
        .clr_hit_o (per_hit),
        .evt_hit_o (duty_hit)
    );

    // clear value is any 8-bit byte
    pme_ctr_unit u_accum_counter (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick2),
        .clr_cmp_i (state_reg.aclr),
        .evt_cmp_i (state_reg.airq),
        .count_o   (cnt2),
        .clr_hit_o (aclr_hit),
        .evt_hit_o (airq_hit)
    );

    // in mode 2, period event and second count share cycle
    assign per_evt     = tick1 & per_hit;
    assign duty_evt    = tick1 & duty_hit & state_reg.oen;
    assign acc_evt     = tick2 & airq_hit;
    assign acc_clr_evt = tick2 & aclr_hit;

    assign wb_go = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    assign wb_wr = wb_go & wb_we_i & wb_sel_i[0];

    always_comb
    begin
        state_next         = state_reg;
        state_next.pre_cnt = state_reg.pre_cnt + PME_PRE_W'(1);
        state_next.in1_q   = first_event_input_i;
        state_next.in2_q   = second_event_input_i;
        state_next.ack     = wb_go;
        state_next.dat     = 32'h0000_0000;

        // Output unit: period last, so equal compares keep idle level
        if (state_reg.oen)
        begin
            // polarity zero goes high on duty
            // polarity one goes low on duty
            if (duty_evt)
                state_next.pwm = ~state_reg.pol;
            // period match returns to idle level
            // idle level for duty ticks of each period
            if (per_evt)
                state_next.pwm = state_reg.pol;
        end
        else
            state_next.pwm = state_reg.pol;

        if (wb_go && !wb_we_i)
        begin
            unique case (wb_adr_i)
                PME_OFS_CLOCK:   state_next.dat[7:0] = {2'h0, state_reg.mode, 1'b0,
                                                        state_reg.pre};
                PME_OFS_CONTROL: state_next.dat[7:0] = {state_reg.oen, state_reg.pol,
                                                        state_reg.sel2, state_reg.sel1};
                PME_OFS_PERIOD:  state_next.dat[7:0] = state_reg.period;
                PME_OFS_DUTY:    state_next.dat[7:0] = state_reg.duty;
                PME_OFS_ACLR:    state_next.dat[7:0] = state_reg.aclr;
                PME_OFS_AIRQ:    state_next.dat[7:0] = state_reg.airq;
                PME_OFS_PWM_CNT: state_next.dat[7:0] = cnt1;
                PME_OFS_ACC_CNT: state_next.dat[7:0] = cnt2;
                PME_OFS_STATUS:  state_next.dat[1:0] = state_reg.pend;
                PME_OFS_IRQ_EN:  state_next.dat[1:0] = state_reg.ien;
                default:         state_next.dat      = 32'h0000_0000;
            endcase
        end

        if (wb_wr)
        begin
            unique case (wb_adr_i)
                PME_OFS_CLOCK:
                begin
                    state_next.mode = pme_mode_t'(wb_dat_i[PME_CLK_MODE_LSB +: 2]);
                    state_next.pre  = wb_dat_i[PME_CLK_PRE_LSB +: 3];
                end
                PME_OFS_CONTROL:
                begin
                    state_next.oen  = wb_dat_i[PME_CTL_OEN_BIT];
                    state_next.pol  = wb_dat_i[PME_CTL_POL_BIT];
                    state_next.sel2 = wb_dat_i[PME_CTL_SEL2_LSB +: 3];
                    state_next.sel1 = wb_dat_i[PME_CTL_SEL1_LSB +: 3];
                end
                PME_OFS_PERIOD: state_next.period = wb_dat_i[7:0];
                PME_OFS_DUTY:   state_next.duty   = wb_dat_i[7:0];
                PME_OFS_ACLR:   state_next.aclr   = wb_dat_i[7:0];
                PME_OFS_AIRQ:   state_next.airq   = wb_dat_i[7:0];
                PME_OFS_STATUS: state_next.pend   = state_reg.pend & ~wb_dat_i[1:0];
                PME_OFS_IRQ_EN: state_next.ien    = wb_dat_i[1:0];
                default:        state_next.ien    = state_reg.ien;
            endcase
        end

        // events set pending, set beats clear
        if (per_evt)
            state_next.pend[PME_ST_PERIOD_BIT] = 1'b1;
        if (acc_evt)
            state_next.pend[PME_ST_ACCUM_BIT] = 1'b1;
        state_next.irq1 = state_next.pend[PME_ST_PERIOD_BIT] & state_next.ien[PME_ST_PERIOD_BIT];
        state_next.irq2 = state_next.pend[PME_ST_ACCUM_BIT] & state_next.ien[PME_ST_ACCUM_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg         <= '0;
            state_reg.mode    <= pme_mode_t'(PME_RST_MODE);
            state_reg.sel1    <= PME_RST_SEL;
            state_reg.sel2    <= PME_RST_SEL;
            state_reg.period  <= PME_RST_BYTE;
            state_reg.duty    <= PME_RST_BYTE;
            state_reg.aclr    <= PME_RST_BYTE;
            state_reg.airq    <= PME_RST_BYTE;
        end
        else
            state_reg <= state_next;
    end

    assign wb_ack_o           = state_reg.ack;
    assign wb_dat_o           = state_reg.dat;
    assign pwm_out_o          = state_reg.pwm;
    assign pwm_oe_o           = state_reg.oen;
    assign period_event_irq_o = state_reg.irq1;
    assign accum_event_irq_o  = state_reg.irq2;

endmodule

/* File: rtl/pme_pkg.sv */
// Constants and types for the dual counter PWM and event unit
package pme_pkg;

    // Word offsets on the Wishbone slave (byte addresses)
    localparam logic [7:0] PME_OFS_CLOCK     = 8'h00;
    localparam logic [7:0] PME_OFS_CONTROL   = 8'h04;
    localparam logic [7:0] PME_OFS_PERIOD    = 8'h08;
    localparam logic [7:0] PME_OFS_DUTY      = 8'h0C;
    localparam logic [7:0] PME_OFS_ACLR      = 8'h10;
    localparam logic [7:0] PME_OFS_AIRQ      = 8'h14;
    localparam logic [7:0] PME_OFS_PWM_CNT   = 8'h18;
    localparam logic [7:0] PME_OFS_ACC_CNT   = 8'h1C;
    localparam logic [7:0] PME_OFS_STATUS    = 8'h20;
    localparam logic [7:0] PME_OFS_IRQ_EN    = 8'h24;

    // Clock register fields
    localparam int PME_CLK_PRE_LSB  = 0;
    localparam int PME_CLK_MODE_LSB = 4;
    // Control register fields
    localparam int PME_CTL_SEL1_LSB = 0;
    localparam int PME_CTL_SEL2_LSB = 3;
    localparam int PME_CTL_POL_BIT  = 6;
    localparam int PME_CTL_OEN_BIT  = 7;
    // Status and enable bits
    localparam int PME_ST_PERIOD_BIT = 0;
    localparam int PME_ST_ACCUM_BIT  = 1;

    // Reset values
    localparam logic [7:0] PME_RST_BYTE = 8'h00;
    localparam logic [1:0] PME_RST_MODE = 2'h0;
    localparam logic [2:0] PME_RST_SEL  = 3'h0;

    // Prescaler width: divide by up to 128
    localparam int PME_PRE_W = 7;

    // Input selector codes
    localparam logic [2:0] PME_SEL_STOP     = 3'h0;
    localparam logic [2:0] PME_SEL_SCALED   = 3'h1;
    localparam logic [2:0] PME_SEL_GATE_LO  = 3'h2;
    localparam logic [2:0] PME_SEL_GATE_HI  = 3'h3;
    localparam logic [2:0] PME_SEL_FALL     = 3'h4;
    localparam logic [2:0] PME_SEL_RISE     = 3'h5;
    localparam logic [2:0] PME_SEL1_BOTH    = 3'h6;
    localparam logic [2:0] PME_SEL1_UNSCALE = 3'h7;
    localparam logic [2:0] PME_SEL2_UNSCALE = 3'h6;

    // Counter modes
    typedef enum logic [1:0] {
        PME_MODE_0 = 2'h0,
        PME_MODE_1 = 2'h1,
        PME_MODE_2 = 2'h2,
        PME_MODE_3 = 2'h3
    } pme_mode_t;

endpackage

/* File: rtl/pme_ctr_unit.sv */
// One 8-bit counter with a clear compare and an event compare
`timescale 1ns/1ps
module pme_ctr_unit (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Count control
    input  wire logic       tick_i,
    input  wire logic [7:0] clr_cmp_i,
    input  wire logic [7:0] evt_cmp_i,
    // Count state
    output logic      [7:0] count_o,
    output logic            clr_hit_o,
    output logic            evt_hit_o
);
    import pme_pkg::*;

    typedef struct packed {
        logic [7:0] count;
    } pme_ctr_state_t;

    pme_ctr_state_t state_reg;
    pme_ctr_state_t state_next;
    logic     [7:0] count_inc;

    assign count_inc = state_reg.count + 8'h01;
    assign count_o   = state_reg.count;
    // Hit when the coming step would reach the compare value
    assign clr_hit_o = (count_inc == clr_cmp_i);
    assign evt_hit_o = (count_inc == evt_cmp_i);

    always_comb
    begin
        state_next = state_reg;
        if (tick_i)
        begin
            if (clr_hit_o)
                state_next.count = PME_RST_BYTE;
            else
                state_next.count = count_inc;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_reg <= '{count: PME_RST_BYTE};
        else
            state_reg <= state_next;
    end

endmodule

/* File: dv/pme_event_unit_monitor.sv */
// Port-level checker for the dual counter PWM and event unit
`timescale 1ns/1ps
module pme_event_unit_monitor (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Pins and requests
    input wire logic        first_event_input_i,
    input wire logic        second_event_input_i,
    input wire logic        pwm_out_o,
    input wire logic        pwm_oe_o,
    input wire logic        period_event_irq_o,
    input wire logic        accum_event_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    read_upper_a: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    period_irq_clear_a: assert property ($fell(period_event_irq_o) |-> wb_ack_o && $past(wb_we_i))
        else $error("period request dropped without write");
    accum_irq_clear_a: assert property ($fell(accum_event_irq_o) |-> wb_ack_o && $past(wb_we_i))
        else $error("accum request dropped without write");
    oe_by_write_a: assert property ($changed(pwm_oe_o) |-> wb_ack_o && $past(wb_we_i))
        else $error("output enable moved without write");
    idle_level_a: assert property (!pwm_oe_o && !$past(pwm_oe_o) && $changed(pwm_out_o) |-> $past(wb_ack_o))
        else $error("disabled output moved");
endmodule

bind pme_event_unit pme_event_unit_monitor i_pme_event_unit_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .first_event_input_i(first_event_input_i),
    .second_event_input_i(second_event_input_i), .pwm_out_o(pwm_out_o),
    .pwm_oe_o(pwm_oe_o), .period_event_irq_o(period_event_irq_o),
    .accum_event_irq_o(accum_event_irq_o)
);

/* File: dv/pme_pin_model.sv */
// Pin-side model driving the two event input pins
`timescale 1ns/1ps
module pme_pin_model (
    // Clock
    input  wire logic clk_i,
    // Event pins
    output logic      first_event_input_o,
    output logic      second_event_input_o
);
    initial
    begin
        first_event_input_o = 1'b0;
        second_event_input_o = 1'b0;
    end

    // Two-cycle level on the pins picked by mask
    task automatic drive(input logic [1:0] mask, input logic [1:0] lvl);
        @(posedge clk_i);
        if (mask[0])
            first_event_input_o <= lvl[0];
        if (mask[1])
            second_event_input_o <= lvl[1];
        @(posedge clk_i);
    endtask

    task automatic pulses(input logic [1:0] mask, input int n);
        repeat (n)
        begin
            drive(mask, 2'b11);
            drive(mask, 2'b00);
        end
    endtask
endmodule

/* File: dv/pme_event_unit_bench.sv */
// Self-checking bench for the dual counter PWM and event unit
`timescale 1ns/1ps
module pme_event_unit_bench;
    import pme_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pin1;
    logic        pin2;
    logic        pwm_out_o;
    logic        pwm_oe_o;
    logic        irq_p;
    logic        irq_a;
    logic [31:0] rd;
    int          n_mismatch;
    int          tests_run;
    int          seed;
    int          per, dut, sc, hi, n, c1, c2, w1, w2, p, a;
    int          md[9] = '{1, 1, 1, 1, 1, 1, 2, 3, 1};
    int          ct[9] = '{5, 4, 6, 40, 32, 56, 45, 45, 18};
    int          pr[9] = '{7, 7, 7, 0, 0, 0, 3, 0, 0};
    int          ac[9] = '{0, 0, 0, 5, 5, 5, 0, 3, 0};
    logic [7:0]  ad[11] = '{8'h18, 8'h1C, 8'h20, 8'h30, 8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                            8'h14, 8'h24};
    logic [7:0]  mk[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h37, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                            8'hFF, 8'h03};

    pme_event_unit i_pme_event_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .first_event_input_i(pin1), .second_event_input_i(pin2), .pwm_out_o(pwm_out_o),
        .pwm_oe_o(pwm_oe_o), .period_event_irq_o(irq_p), .accum_event_irq_o(irq_a));
    pme_pin_model i_pme_pin_model (.clk_i(clk_i), .first_event_input_o(pin1),
        .second_event_input_o(pin2));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input int dat, input logic [3:0] s);
        int t;
        t = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= 32'(dat);
        wb_sel_i <= s;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (wb_ack_o !== 1'b1 && t < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (t >= 50)
            n_mismatch++;
    endtask

    task automatic wr(input logic [7:0] adr, input int dat);
        bus(1'b1, adr, dat, 4'hF);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input int exp);
        bus(1'b0, adr, 0, 4'hF);
        check(what, rd, 32'(exp));
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // Ticks from n pin pulses for one selector code
    function automatic int ticks(input int code, input int first, input int n);
        if (code == 4 || code == 5)
            return n;
        if (code == 2 || (code == 6 && first == 1))
            return 2 * n;
        return 0;
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #(20 * 60000);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        seed = 32'h3d2d;
        n_mismatch = 0;
        tests_run = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        do_reset();
        // Reset values, access kinds, unmapped place
        for (int i = 0; i < 11; i++)
        begin
            n = $unsigned($random(seed)) % 256;
            rd_chk("reset value", ad[i], 0);
            wr(ad[i], n);
            rd_chk("readback", ad[i], n & mk[i]);
        end
        do_reset();
        bus(1'b1, PME_OFS_PERIOD, 8'hAA, 4'h0);
        rd_chk("masked write", PME_OFS_PERIOD, 0);
        // Counter modes and selector codes from pin edges
        for (int i = 0; i < 9; i++)
        begin
            n = 5 + $unsigned($random(seed)) % 36;
            do_reset();
            wr(PME_OFS_PERIOD, pr[i]);
            wr(PME_OFS_ACLR, ac[i]);
            wr(PME_OFS_CLOCK, md[i] << 4);
            wr(PME_OFS_CONTROL, ct[i]);
            i_pme_pin_model.pulses(2'b11, n);
            repeat (3) @(posedge clk_i);
            p = (pr[i] == 0) ? 256 : pr[i];
            a = (ac[i] == 0) ? 256 : ac[i];
            w2 = ticks(ct[i] >> 3, 2, n);
            w1 = ticks(ct[i] & 7, 1, n);
            w2 = (md[i] == 2) ? w1 / p : w2;
            w1 = (md[i] == 3) ? w2 / a : w1;
            rd_chk("pwm counter", PME_OFS_PWM_CNT, w1 % p);
            rd_chk("accum counter", PME_OFS_ACC_CNT, w2 % a);
        end
        // Unscaled clock on both selectors while the prescaler divides by 128
        do_reset();
        wr(PME_OFS_CLOCK, 8'h17);
        wr(PME_OFS_CONTROL, 8'h37);
        n = $unsigned($random(seed)) % 200;
        repeat (n) @(posedge clk_i);
        wr(PME_OFS_CONTROL, 8'h00);
        rd_chk("unscaled pwm counter", PME_OFS_PWM_CNT, n + 3);
        rd_chk("unscaled accum counter", PME_OFS_ACC_CNT, n + 3);
        // PWM shape for every prescale code, both polarities
        for (int c = 0; c < 8; c++)
        begin
            per = 3 + $unsigned($random(seed)) % 8;
            dut = 1 + $unsigned($random(seed)) % (per - 1);
            sc = 1 << c;
            do_reset();
            wr(PME_OFS_PERIOD, per);
            wr(PME_OFS_DUTY, dut);
            wr(PME_OFS_IRQ_EN, 1);
            wr(PME_OFS_CLOCK, c);
            wr(PME_OFS_CONTROL, {c[0], 6'h01} | 8'h80);
            repeat ((per + 1) * sc + 4) @(posedge clk_i);
            hi = 0;
            repeat (2 * per * sc)
            begin
                @(posedge clk_i);
                hi += (pwm_out_o === 1'b1);
            end
            check("high cycles", hi, c[0] ? 2 * dut * sc : 2 * (per - dut) * sc);
            check("period irq", irq_p, 1);
            check("output enable", pwm_oe_o, 1);
        end
        // Software releases the pin, output holds its idle level
        wr(PME_OFS_CONTROL, 8'h41);
        hi = 0;
        repeat (2 * per * sc)
        begin
            @(posedge clk_i);
            hi += (pwm_out_o === 1'b1);
        end
        check("idle high cycles", hi, 2 * per * sc);
        check("output released", pwm_oe_o, 0);
        // Accum request: masked, enabled, cleared
        do_reset();
        wr(PME_OFS_AIRQ, 3);
        wr(PME_OFS_CONTROL, 8'h28);
        i_pme_pin_model.pulses(2'b10, 3);
        repeat (3) @(posedge clk_i);
        check("accum irq masked", irq_a, 0);
        rd_chk("status pending", PME_OFS_STATUS, 2);
        wr(PME_OFS_IRQ_EN, 2);
        repeat (2) @(posedge clk_i);
        check("accum irq enabled", irq_a, 1);
        wr(PME_OFS_STATUS, 2);
        repeat (2) @(posedge clk_i);
        check("accum irq cleared", irq_a, 0);
        rd_chk("status cleared", PME_OFS_STATUS, 0);
        print_verdict();
    end
endmodule
